// ---- hdl/lie_defs.vh ----
/*
 Constants for the ladder input logic evaluator: operation codes, function
 codes, stack depth and sizes of the edge-history memory.
 Assumes it is included by bare name from hdl/ design files.
*/
`ifndef LIE_DEFS_VH
`define LIE_DEFS_VH

`define LIE_OP_W          4
`define LIE_OP_NOP        4'h0
`define LIE_OP_START      4'h1
`define LIE_OP_START_INV  4'h2
`define LIE_OP_SER        4'h3
`define LIE_OP_SER_INV    4'h4
`define LIE_OP_PAR        4'h5
`define LIE_OP_PAR_INV    4'h6
`define LIE_OP_SER_JOIN   4'h7
`define LIE_OP_PAR_JOIN   4'h8
`define LIE_OP_FUNC       4'h9

`define LIE_POS_W         2
`define LIE_POS_START     2'h0
`define LIE_POS_SER       2'h1
`define LIE_POS_PAR       2'h2

`define LIE_FC_W          10
`define LIE_FC_INVERT     10'd520
`define LIE_FC_RISE       10'd521
`define LIE_FC_FALL       10'd522
`define LIE_FC_TEST       10'd350
`define LIE_FC_TEST_INV   10'd351

`define LIE_WORD_W        16
`define LIE_BITN_W        4
`define LIE_STACK_DEPTH   8
`define LIE_SP_W          4
`define LIE_SP_FULL       4'h8
`define LIE_LOC_W         6
`define LIE_LOC_COUNT     64

`endif

// ---- hdl/lie_evaluator.v ----
/*
 Ladder input logic evaluator: executes one sequence-input instruction per
 valid cycle and keeps the execution condition, a block-result stack and a
 per-location edge history.
 Assumes fetch and operand read logic on clk_in presents decoded operation,
 operand bit, source word and bit number in the same cycle as instr_valid_in.
*/
`timescale 1ns/1ps
`include "lie_defs.vh"

// Behaviour
// - Start-load begins a block with condition equal to operand bit.
// - Inverted start-load begins a block with complemented operand bit.
// - Series contact ANDs condition with operand bit.
// - Inverted series contact ANDs condition with complemented operand bit.
// - Parallel contact ORs condition with operand bit.
// - Inverted parallel contact ORs condition with complemented operand bit.
// - Series block join ANDs the two most recent block results.
// - Parallel block join ORs the two most recent block results.
// - Function 520 complements the current condition.
// - Function 521 gives true for one scan on false-to-true change.
// - Function 522 gives true for one scan on true-to-false change.
// - Function 350 yields the selected bit of the source word.
// - Function 351 yields the complement of the selected word bit.
// - Word bit tests work as block start, series or parallel term.
module lie_evaluator
(
    input  wire                     clk_in,
    input  wire                     srst_in,
    input  wire                     instr_valid_in,
    input  wire [`LIE_OP_W-1:0]     op_in,
    input  wire [`LIE_FC_W-1:0]     func_code_in,
    input  wire [`LIE_POS_W-1:0]    position_in,
    input  wire                     operand_bit_in,
    input  wire [`LIE_WORD_W-1:0]   source_word_in,
    input  wire [`LIE_BITN_W-1:0]   bit_number_in,
    input  wire [`LIE_LOC_W-1:0]    location_in,
    input  wire                     scan_start_in,
    output reg                      exec_cond_out,
    output reg                      done_out,
    output reg                      stack_error_out
);

    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;

    reg  [1:0]                  state_next;
    reg                         cond_reg;
    reg                         cond_next;
    reg  [`LIE_SP_W-1:0]        sp_reg;
    reg  [`LIE_SP_W-1:0]        sp_next;
    reg                         push;
    reg                         err_next;
    reg  [`LIE_STACK_DEPTH-1:0] stack_mem;
    reg  [`LIE_STACK_DEPTH-1:0] stack_wr;
    // Edge history: one bit per program location
    reg  [`LIE_LOC_COUNT-1:0]   hist_mem;
    reg  [`LIE_LOC_COUNT-1:0]   hist_sel;
    reg                         hist_wr;
    reg                         top_bit;
    reg                         test_bit;
    reg                         term;
    reg                         prev_in;
    reg  [`LIE_SP_W-1:0]        top_idx;

    // Function position start/series/parallel reuses the contact datapath
    always @*
    begin
        // An empty stack reads a stale entry here, but no join then uses it
        top_idx    = sp_reg - 4'h1;
        top_bit    = stack_mem[top_idx[2:0]];
        test_bit   = source_word_in[bit_number_in];
        prev_in    = hist_mem[location_in];
        state_next = ST_IDLE;
        cond_next  = cond_reg;
        sp_next    = sp_reg;
        push       = 1'b0;
        hist_wr    = 1'b0;
        err_next   = 1'b0;
        stack_wr   = {`LIE_STACK_DEPTH{1'b0}};
        hist_sel   = {`LIE_LOC_COUNT{1'b0}};
        term       = operand_bit_in;
        if (instr_valid_in)
        begin
            state_next = ST_EXEC;
            case (op_in)
                `LIE_OP_START:     term = operand_bit_in;
                `LIE_OP_START_INV: term = ~operand_bit_in;
                `LIE_OP_SER:       term = operand_bit_in;
                `LIE_OP_SER_INV:   term = ~operand_bit_in;
                `LIE_OP_PAR:       term = operand_bit_in;
                `LIE_OP_PAR_INV:   term = ~operand_bit_in;
                default:           term = (func_code_in == `LIE_FC_TEST_INV) ?
                                          ~test_bit : test_bit;
            endcase
            case (op_in)
                `LIE_OP_START, `LIE_OP_START_INV:
                begin
                    push      = 1'b1;
                    cond_next = term;
                end
                `LIE_OP_SER, `LIE_OP_SER_INV:
                    cond_next = cond_reg & term;
                `LIE_OP_PAR, `LIE_OP_PAR_INV:
                    cond_next = cond_reg | term;
                `LIE_OP_SER_JOIN, `LIE_OP_PAR_JOIN:
                begin
                    // Join on an empty stack keeps the condition and is flagged
                    if (sp_reg == 4'h0)
                        err_next = 1'b1;
                    else
                    begin
                        sp_next = sp_reg - 4'h1;
                        if (op_in == `LIE_OP_SER_JOIN)
                            cond_next = top_bit & cond_reg;
                        else
                            cond_next = top_bit | cond_reg;
                    end
                end
                `LIE_OP_FUNC:
                begin
                    case (func_code_in)
                        `LIE_FC_INVERT:
                            cond_next = ~cond_reg;
                        `LIE_FC_RISE:
                        begin
                            cond_next = cond_reg & ~prev_in;
                            hist_wr   = 1'b1;
                        end
                        `LIE_FC_FALL:
                        begin
                            cond_next = ~cond_reg & prev_in;
                            hist_wr   = 1'b1;
                        end
                        `LIE_FC_TEST, `LIE_FC_TEST_INV:
                        begin
                            case (position_in)
                                `LIE_POS_START:
                                begin
                                    push      = 1'b1;
                                    cond_next = term;
                                end
                                `LIE_POS_SER: cond_next = cond_reg & term;
                                `LIE_POS_PAR: cond_next = cond_reg | term;
                                // The fourth position code has no meaning
                                default:      err_next  = 1'b1;
                            endcase
                        end
                        default: err_next = 1'b1;
                    endcase
                end
                default: state_next = ST_EXEC;
            endcase
            // Stack holds only pending blocks; overflow is flagged, not wrapped
            if (push)
            begin
                if (sp_reg == `LIE_SP_FULL)
                    err_next = 1'b1;
                else
                begin
                    sp_next               = sp_reg + 4'h1;
                    stack_wr[sp_reg[2:0]] = 1'b1;
                end
            end
            // Only the executing location's history bit is rewritten
            if (hist_wr)
                hist_sel[location_in] = 1'b1;
        end
    end

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cond_reg        <= 1'b0;
            sp_reg          <= 4'h0;
            exec_cond_out   <= 1'b0;
            done_out        <= 1'b0;
            stack_error_out <= 1'b0;
        end
        else
        begin
            // A scan start wins over the result so every scan begins clean
            cond_reg        <= scan_start_in ? 1'b0 : cond_next;
            sp_reg          <= scan_start_in ? 4'h0 : sp_next;
            // Idle cycles hold the last answer, even across a scan clear
            exec_cond_out   <= instr_valid_in ? cond_next : exec_cond_out;
            done_out        <= (state_next == ST_EXEC);
            stack_error_out <= err_next;
        end
    end

    // One flop per stack entry; the pushed value is the pending block result
    genvar gs;
    generate
        for (gs = 0; gs < `LIE_STACK_DEPTH; gs = gs + 1)
        begin : g_stack
            always @(posedge clk_in)
            begin
                if (!srst_in && stack_wr[gs])
                    stack_mem[gs] <= cond_reg;
            end
        end
    endgenerate

    // History survives scans; cleared only by reset so first edge is seen
    genvar gh;
    generate
        for (gh = 0; gh < `LIE_LOC_COUNT; gh = gh + 1)
        begin : g_hist
            always @(posedge clk_in)
            begin
                if (srst_in)
                    hist_mem[gh] <= 1'b0;
                else if (hist_sel[gh])
                    hist_mem[gh] <= cond_reg;
            end
        end
    endgenerate

endmodule

// ---- dv/lie_evaluator_asserts.sv ----
/* Port assertions for lie_evaluator.
   Assumes clk_in is the only clock and srst_in a synchronous high reset. */
`timescale 1ns/1ps
`include "lie_defs.vh"
module lie_evaluator_asserts
(
    input wire                   clk_in,
    input wire                   srst_in,
    input wire                   instr_valid_in,
    input wire [`LIE_OP_W-1:0]   op_in,
    input wire [`LIE_FC_W-1:0]   func_code_in,
    input wire [`LIE_POS_W-1:0]  position_in,
    input wire                   operand_bit_in,
    input wire [`LIE_WORD_W-1:0] source_word_in,
    input wire [`LIE_BITN_W-1:0] bit_number_in,
    input wire                   scan_start_in,
    input wire                   exec_cond_out,
    input wire                   done_out,
    input wire                   stack_error_out
);
    // After a scan clear the output lags the live condition, so chain only on plain steps
    reg  chain_reg;
    wire go  = instr_valid_in && !scan_start_in;
    wire ch  = go && chain_reg;
    wire fn  = go && op_in == `LIE_OP_FUNC;
    wire sel = source_word_in[bit_number_in];
    always @(posedge clk_in)
        chain_reg <= !srst_in && go;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    AST_IDLE: assert property (!instr_valid_in |=> !done_out && !stack_error_out &&
        $stable(exec_cond_out)) else $error("idle cycle changed outputs");
    AST_START: assert property (go && op_in == `LIE_OP_START |=> done_out &&
        exec_cond_out == $past(operand_bit_in)) else $error("start wrong");
    AST_START_INV: assert property (go && op_in == `LIE_OP_START_INV |=>
        exec_cond_out != $past(operand_bit_in)) else $error("inverted start wrong");
    AST_SER: assert property (ch && op_in == `LIE_OP_SER |=> exec_cond_out ==
        ($past(exec_cond_out) & $past(operand_bit_in))) else $error("series wrong");
    AST_SER_INV: assert property (ch && op_in == `LIE_OP_SER_INV |=> exec_cond_out ==
        ($past(exec_cond_out) & !$past(operand_bit_in))) else $error("series inv wrong");
    AST_PAR: assert property (ch && op_in == `LIE_OP_PAR |=> exec_cond_out ==
        ($past(exec_cond_out) | $past(operand_bit_in))) else $error("parallel wrong");
    AST_INVERT: assert property (ch && fn && func_code_in == `LIE_FC_INVERT |=>
        exec_cond_out != $past(exec_cond_out)) else $error("invert wrong");
    AST_RISE: assert property (ch && fn && func_code_in == `LIE_FC_RISE |=>
        !exec_cond_out || $past(exec_cond_out)) else $error("rise without true input");
    AST_FALL: assert property (ch && fn && func_code_in == `LIE_FC_FALL |=>
        !exec_cond_out || !$past(exec_cond_out)) else $error("fall with true input");
    AST_TEST: assert property (fn && func_code_in == `LIE_FC_TEST && position_in ==
        `LIE_POS_START |=> exec_cond_out == $past(sel)) else $error("bit test wrong");
endmodule
bind lie_evaluator lie_evaluator_asserts u_chk (.clk_in(clk_in), .srst_in(srst_in),
    .instr_valid_in(instr_valid_in), .op_in(op_in), .func_code_in(func_code_in),
    .position_in(position_in), .operand_bit_in(operand_bit_in),
    .source_word_in(source_word_in), .bit_number_in(bit_number_in),
    .scan_start_in(scan_start_in), .exec_cond_out(exec_cond_out), .done_out(done_out),
    .stack_error_out(stack_error_out));

// ---- dv/lie_evaluator_tb_top.sv ----
/* Self-checking bench for lie_evaluator.
   Assumes fixed one-cycle answer latency and scan_start_in clearing the stack. */
`timescale 1ns/1ps
`include "lie_defs.vh"
module lie_evaluator_tb_top;
    reg                     clk_in = 1'b0;
    reg                     srst_in = 1'b1;
    reg                     instr_valid_in = 1'b0;
    reg  [`LIE_OP_W-1:0]    op_in = 4'h0;
    reg  [`LIE_FC_W-1:0]    func_code_in = 10'h000;
    reg  [`LIE_POS_W-1:0]   position_in = 2'h0;
    reg                     operand_bit_in = 1'b0;
    reg  [`LIE_WORD_W-1:0]  source_word_in = 16'ha5c3;
    reg  [`LIE_BITN_W-1:0]  bit_number_in = 4'h0;
    reg  [`LIE_LOC_W-1:0]   location_in = 6'h00;
    reg                     scan_start_in = 1'b0;
    wire                    exec_cond_out;
    wire                    done_out;
    wire                    stack_error_out;
    reg  [4:0]              seq = 5'h0d;
    reg                     p;
    reg                     t;
    integer                 error_cnt = 0;
    integer                 compares = 0;
    integer                 i, j, k;
    always #12.5 clk_in = ~clk_in;
    lie_evaluator dut (.clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
        .op_in(op_in), .func_code_in(func_code_in), .position_in(position_in),
        .operand_bit_in(operand_bit_in), .source_word_in(source_word_in),
        .bit_number_in(bit_number_in), .location_in(location_in),
        .scan_start_in(scan_start_in), .exec_cond_out(exec_cond_out), .done_out(done_out),
        .stack_error_out(stack_error_out));
    task chk(input v, input e);
        begin
            compares = compares + 1;
            if (v !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0t got %b want %b", $time, v, e);
            end
        end
    endtask
    task ins(input [`LIE_OP_W-1:0] op, input [`LIE_FC_W-1:0] fc, input [1:0] pos, input b);
        begin
            @(posedge clk_in);
            #1;
            instr_valid_in = 1'b1;
            op_in = op;
            func_code_in = fc;
            position_in = pos;
            operand_bit_in = b;
        end
    endtask
    // Checks the answer to the last instruction issued
    task res(input c, input er);
        begin
            @(posedge clk_in);
            #1;
            instr_valid_in = 1'b0;
            chk(exec_cond_out, c);
            chk(done_out, 1'b1);
            chk(stack_error_out, er);
        end
    endtask
    task scan;
        begin
            @(posedge clk_in);
            #1;
            instr_valid_in = 1'b0;
            scan_start_in = 1'b1;
            @(posedge clk_in);
            #1;
            scan_start_in = 1'b0;
        end
    endtask
    task end_sim;
        begin
            $display("compares %0d errors %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task t_contacts;
        for (j = 3; j < 7; j = j + 1)
            for (i = 0; i < 4; i = i + 1)
            begin
                ins(`LIE_OP_START_INV, 10'h000, 2'h0, ~i[1]);
                ins(j[3:0], 10'h000, 2'h0, i[0]);
                res(j == 3 ? i[1] & i[0] : j == 4 ? i[1] & ~i[0] :
                    j == 5 ? i[1] | i[0] : i[1] | ~i[0], 1'b0);
            end
    endtask
    task t_blocks;
        begin
            for (i = 0; i < 8; i = i + 1)
            begin
                scan;
                ins(`LIE_OP_START, 10'h000, 2'h0, i[0]);
                ins(`LIE_OP_START, 10'h000, 2'h0, i[1]);
                ins(i[2] ? `LIE_OP_PAR_JOIN : `LIE_OP_SER_JOIN, 10'h000, 2'h0, 1'b0);
                res(i[2] ? i[0] | i[1] : i[0] & i[1], 1'b0);
            end
            ins(`LIE_OP_START, 10'h000, 2'h0, 1'b1);
            scan;
            ins(`LIE_OP_SER_JOIN, 10'h000, 2'h0, 1'b1);
            res(1'b0, 1'b1);
            for (k = 0; k < 9; k = k + 1)
                ins(`LIE_OP_START, 10'h000, 2'h0, 1'b1);
            res(1'b1, 1'b1);
        end
    endtask
    task t_func;
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                ins(`LIE_OP_START, 10'h000, 2'h0, i[0]);
                ins(`LIE_OP_FUNC, `LIE_FC_INVERT, 2'h0, 1'b0);
                res(~i[0], 1'b0);
            end
            // Separate locations keep the two edge histories apart
            for (j = 0; j < 2; j = j + 1)
            begin
                p = 1'b0;
                location_in = j ? 6'h09 : 6'h05;
                for (k = 0; k < 5; k = k + 1)
                begin
                    scan;
                    ins(`LIE_OP_START, 10'h000, 2'h0, seq[k]);
                    ins(`LIE_OP_FUNC, j ? `LIE_FC_FALL : `LIE_FC_RISE, 2'h0, 1'b0);
                    res(j ? ~seq[k] & p : seq[k] & ~p, 1'b0);
                    p = seq[k];
                end
            end
        end
    endtask
    task t_test;
        for (j = 0; j < 6; j = j + 1)
            for (k = 0; k < 16; k = k + 5)
            begin
                scan;
                bit_number_in = k[3:0];
                t = source_word_in[k] ^ j[0];
                ins(`LIE_OP_START, 10'h000, 2'h0, k[0]);
                ins(`LIE_OP_FUNC, j[0] ? `LIE_FC_TEST_INV : `LIE_FC_TEST, j[2:1], 1'b0);
                res(j < 2 ? t : j < 4 ? k[0] & t : k[0] | t, 1'b0);
            end
    endtask
    // A bit test in the undefined position is flagged and keeps the condition
    task t_bad;
        begin
            scan;
            ins(`LIE_OP_START, 10'h000, 2'h0, 1'b1);
            ins(`LIE_OP_FUNC, `LIE_FC_TEST, 2'h3, 1'b0);
            res(1'b1, 1'b1);
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        chk(exec_cond_out, 1'b0);
        t_contacts;
        t_blocks;
        t_func;
        t_test;
        t_bad;
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        error_cnt = error_cnt + 1;
        end_sim;
    end
endmodule
